/* light_cfg_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// lighting configuration register group.
// Assumes a byte-wide register port with 8-bit addresses.
// Functional notes
// - Six bank enable bits 0..5 for banks A..F, reset disabled.
// - Pattern enables at even bits, light scaling enables at odd bits.
// - Pattern-enabled bank on second/third mapper ignores zone target.
// - Scaler code n selects scaling factor (n+1)/16.
// - First scaler register: zone 4 high, zone 3 low, full scale.
// - Second scaler register: zone 2 high, zone 1 low, full scale.
// - Zone 0 scaler in low nibble of third register, resets 0000.
// - Boost register: polarity bit 3, threshold 2:1, frequency bit 0.
// - Resistor code zero makes sensor input high impedance, reset.
// - Nonzero resistor code D gives 10uA per step of current.
// - Averaging period is 17.92 ms times two to the code.
// - Bit 2 zero enables fast startup, one disables it.
// - Bit 1 zero selects analog input, one selects PWM input.
// - Bit 0 enables the light interface; bits 7:6 unused.
// - Bank control 0X register, 10 second mapper, 11 third mapper.
`ifndef LIGHT_CFG_DEFS_SVH
`define LIGHT_CFG_DEFS_SVH

`define ADDR_BANK_ENABLE 8'h27
`define ADDR_PATTERN_ENABLE_SCALING 8'h28
`define ADDR_ZONE_SCALER_HIGH 8'h29
`define ADDR_ZONE_SCALER_MID 8'h2A
`define ADDR_ZONE_SCALER_LOW 8'h2B
`define ADDR_BOOST_PROTECT_FREQ_POLARITY 8'h2C
`define ADDR_LIGHT_SENSE_RESISTOR_SELECT 8'h30
`define ADDR_LIGHT_SENSE_CONFIG 8'h31

`define RST_BANK_ENABLE 8'h00
`define RST_PATTERN_ENABLE_SCALING 8'h00
`define RST_ZONE_SCALER_HIGH 8'hFF
`define RST_ZONE_SCALER_MID 8'hFF
`define RST_ZONE_SCALER_LOW 8'h00
`define RST_BOOST 8'h00
`define RST_RESISTOR 8'h00
`define RST_LIGHT_CONFIG 8'h20

`define MASK_BANK_ENABLE 8'h3F
`define MASK_SCALER_LOW 8'h0F
`define MASK_BOOST 8'h0F
`define MASK_RESISTOR 8'h7F
`define MASK_LIGHT_CONFIG 8'h3F

`define POS_PWM_POLARITY 3
`define POS_THRESH_LSB 1
`define POS_FREQ 0
`define POS_AVG_LSB 3
`define POS_FAST_OFF 2
`define POS_INPUT_PWM 1
`define POS_SENSE_EN 0

// Averaging base period in microseconds and its cycle count at 100 MHz
`define AVG_BASE_US 17920
`define CLK_MHZ 100
`define AVG_BASE_CYCLES (`AVG_BASE_US * `CLK_MHZ)
// Sensor current per resistor code step in nanoamps
`define SENSE_STEP_NA 10000

`endif

/* light_cfg_host.sv */
// Host side of the register port: single-byte writes and reads.
// Assumes the block decodes read data combinationally.
`timescale 1ns/10ps
`default_nettype none

module light_cfg_host (
  // Clock
  input wire logic clk,
  // Register port toward the block
  output var logic [7:0] reg_addr,
  output var logic reg_wr,
  output var logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // Strobe spans one rising edge; stale data is inverted afterwards
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic h);
    @(negedge clk);
    reg_addr = a;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

/* light_cfg_pkg.sv */
// Types shared by the lighting configuration register group.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package light_cfg_pkg;
  typedef enum logic [1:0] {
    THRESH_16V = 2'h0,
    THRESH_24V = 2'h1,
    THRESH_32V = 2'h2,
    THRESH_40V = 2'h3
  } overvoltage_threshold_t;
  typedef enum logic [1:0] {
    CTRL_REG0 = 2'h0,
    CTRL_REG1 = 2'h1,
    CTRL_MAPPER2 = 2'h2,
    CTRL_MAPPER3 = 2'h3
  } bank_ctrl_t;
endpackage
`default_nettype wire

/* lighting_bank_als_config_regs.sv */
// Configuration register group of the lighting controller: bank and
// pattern enables, zone scalers, boost settings and light sensing setup.
// Assumes the serial control slave delivers one-cycle write strobes and
// samples read data combinationally decoded from stored registers.
`timescale 1ns/10ps
`default_nettype none
`include "light_cfg_defs.svh"

module lighting_bank_als_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port from the serial control slave
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Current control of low-voltage banks C..F, from their config regs
  input wire logic [7:0] lv_bank_ctrl,
  input wire logic [3:0] lv_bank_pattern_sel,
  // Detected zone (0..4) and raw PWM sensor pin
  input wire logic [2:0] light_zone,
  input wire logic pwm_pin,
  // Decoded controls
  output logic [5:0] bank_en,
  output logic [3:0] pattern_en,
  output logic [3:0] pattern_scale_en,
  output logic [3:0] mapper_target_ignore,
  output logic [4:0] pattern_scale_num [4],
  output logic [1:0] overvoltage_threshold,
  output logic boost_freq_1mhz,
  output logic pwm_active,
  output logic [6:0] light_sense_gain_resistor,
  output logic sense_input_hiz,
  output logic [13:0] sense_full_scale_ua,
  output logic [31:0] avg_period_cycles,
  output logic fast_startup_en,
  output logic sense_input_pwm,
  output logic ambient_light_sensing_en
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Scaler code n gives factor (n+1)/16: numerator 1..16
  function automatic logic [4:0] scale_num(input logic [3:0] code);
    scale_num = {1'b0, code} + 5'h01;
  endfunction

  function automatic logic [3:0] zone_code(input logic [2:0] zone,
                                           input logic [7:0] hi,
                                           input logic [7:0] mid,
                                           input logic [7:0] lo);
    unique case (zone)
      3'h0: zone_code = lo[3:0];
      3'h1: zone_code = mid[3:0];
      3'h2: zone_code = mid[7:4];
      3'h3: zone_code = hi[3:0];
      default: zone_code = hi[7:4];
    endcase
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] bank_enable_reg;
  logic [7:0] pattern_enable_scaling_reg;
  logic [7:0] zone_scaler_high_reg;
  logic [7:0] zone_scaler_mid_reg;
  logic [7:0] zone_scaler_low_reg;
  logic [7:0] boost_reg;
  logic [7:0] resistor_reg;
  logic [7:0] light_config_reg;
  logic [2:0] pwm_sync_reg;
  logic pwm_level_reg;

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = reg_wr && (reg_addr == a);
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_enable_reg <= `RST_BANK_ENABLE;
    end else if (wr_to(`ADDR_BANK_ENABLE)) begin
      bank_enable_reg <= reg_wdata & `MASK_BANK_ENABLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_enable_scaling_reg <= `RST_PATTERN_ENABLE_SCALING;
    end else if (wr_to(`ADDR_PATTERN_ENABLE_SCALING)) begin
      pattern_enable_scaling_reg <= reg_wdata;
    end
  end

  // zone scalers with their reset codes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zone_scaler_high_reg <= `RST_ZONE_SCALER_HIGH;
      zone_scaler_mid_reg <= `RST_ZONE_SCALER_MID;
      zone_scaler_low_reg <= `RST_ZONE_SCALER_LOW;
    end else begin
      if (wr_to(`ADDR_ZONE_SCALER_HIGH)) begin
        zone_scaler_high_reg <= reg_wdata;
      end
      if (wr_to(`ADDR_ZONE_SCALER_MID)) begin
        zone_scaler_mid_reg <= reg_wdata;
      end
      if (wr_to(`ADDR_ZONE_SCALER_LOW)) begin
        zone_scaler_low_reg <= reg_wdata & `MASK_SCALER_LOW;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_reg <= `RST_BOOST;
    end else if (wr_to(`ADDR_BOOST_PROTECT_FREQ_POLARITY)) begin
      boost_reg <= reg_wdata & `MASK_BOOST;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resistor_reg <= `RST_RESISTOR;
    end else if (wr_to(`ADDR_LIGHT_SENSE_RESISTOR_SELECT)) begin
      resistor_reg <= reg_wdata & `MASK_RESISTOR;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      light_config_reg <= `RST_LIGHT_CONFIG;
    end else if (wr_to(`ADDR_LIGHT_SENSE_CONFIG)) begin
      light_config_reg <= reg_wdata & `MASK_LIGHT_CONFIG;
    end
  end

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  // Unmapped addresses read zero and drop reg_hit so the slave can nack
  always_comb begin
    reg_hit = 1'b1;
    unique case (reg_addr)
      `ADDR_BANK_ENABLE: reg_rdata = bank_enable_reg;
      `ADDR_PATTERN_ENABLE_SCALING: reg_rdata = pattern_enable_scaling_reg;
      `ADDR_ZONE_SCALER_HIGH: reg_rdata = zone_scaler_high_reg;
      `ADDR_ZONE_SCALER_MID: reg_rdata = zone_scaler_mid_reg;
      `ADDR_ZONE_SCALER_LOW: reg_rdata = zone_scaler_low_reg;
      `ADDR_BOOST_PROTECT_FREQ_POLARITY: reg_rdata = boost_reg;
      `ADDR_LIGHT_SENSE_RESISTOR_SELECT: reg_rdata = resistor_reg;
      `ADDR_LIGHT_SENSE_CONFIG: reg_rdata = light_config_reg;
      default: begin
        reg_rdata = 8'h00;
        reg_hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Decoded controls
  // ------------------------------------------------------------
  assign bank_en = bank_enable_reg[5:0];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pat
      assign pattern_en[g] = pattern_enable_scaling_reg[2 * g];
      assign pattern_scale_en[g] = pattern_enable_scaling_reg[2 * g + 1];
      // mapper targets dropped under pattern control
      assign mapper_target_ignore[g] = lv_bank_ctrl[2 * g + 1] &&
        lv_bank_pattern_sel[g];
      // scaling by current zone, else full scale
      assign pattern_scale_num[g] = pattern_scale_en[g] ?
        scale_num(zone_code(light_zone, zone_scaler_high_reg,
          zone_scaler_mid_reg, zone_scaler_low_reg)) : 5'h10;
    end
  endgenerate

  assign overvoltage_threshold = boost_reg[`POS_THRESH_LSB +: 2];
  assign boost_freq_1mhz = boost_reg[`POS_FREQ];

  // Three-stage sync; level changes once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_sync_reg <= 3'h0;
    end else begin
      pwm_sync_reg <= {pwm_sync_reg[1:0], pwm_pin};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_level_reg <= 1'b0;
    end else if (pwm_sync_reg[1] == pwm_sync_reg[2]) begin
      pwm_level_reg <= pwm_sync_reg[2];
    end
  end

  assign pwm_active = pwm_level_reg ^ boost_reg[`POS_PWM_POLARITY];

  // gain resistor code and full-scale current
  assign light_sense_gain_resistor = resistor_reg[6:0];
  assign sense_input_hiz = (resistor_reg[6:0] == 7'h00);
  assign sense_full_scale_ua = 14'(resistor_reg[6:0]) * 14'h00A;

  // averaging period doubles per code step
  assign avg_period_cycles = 32'(`AVG_BASE_CYCLES) <<
    light_config_reg[`POS_AVG_LSB +: 3];
  assign fast_startup_en = !light_config_reg[`POS_FAST_OFF];
  assign sense_input_pwm = light_config_reg[`POS_INPUT_PWM];
  assign ambient_light_sensing_en = light_config_reg[`POS_SENSE_EN];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bank_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_to(`ADDR_BANK_ENABLE) |=> bank_en == $past(reg_wdata[5:0]))
    else $error("bank enable not written");
  a_bank_unused: assert property (
    @(posedge clk) disable iff (!rst_b)
    bank_enable_reg[7:6] == 2'h0)
    else $error("unused bank bits set");
  a_pattern_bits: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_to(`ADDR_PATTERN_ENABLE_SCALING) |=> pattern_en[1] ==
    $past(reg_wdata[2]) && pattern_scale_en[3] == $past(reg_wdata[7]))
    else $error("pattern bits misplaced");
  a_mapper_ignore: assert property (
    @(posedge clk) disable iff (!rst_b)
    mapper_target_ignore[0] == (lv_bank_pattern_sel[0] && lv_bank_ctrl[1:0]
    inside {light_cfg_pkg::CTRL_MAPPER2, light_cfg_pkg::CTRL_MAPPER3}))
    else $error("mapper ignore wrong");
  a_mapper_register: assert property (
    @(posedge clk) disable iff (!rst_b)
    lv_bank_ctrl[3:2] inside {light_cfg_pkg::CTRL_REG0,
    light_cfg_pkg::CTRL_REG1} |-> !mapper_target_ignore[1])
    else $error("register control dropped");
  a_scale_zone0: assert property (
    @(posedge clk) disable iff (!rst_b)
    pattern_scale_en[0] && light_zone == 3'h0 |->
    pattern_scale_num[0] == {1'b0, zone_scaler_low_reg[3:0]} + 5'h01)
    else $error("zone 0 scale wrong");
  a_scaler_high: assert property (
    @(posedge clk) disable iff (!rst_b)
    pattern_scale_en[2] && light_zone == 3'h4 |->
    pattern_scale_num[2] == {1'b0, zone_scaler_high_reg[7:4]} + 5'h01)
    else $error("zone 4 scale wrong");
  a_scaler_mid: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_to(`ADDR_ZONE_SCALER_MID) |=> zone_scaler_mid_reg == $past(reg_wdata))
    else $error("mid scaler not written");
  a_zone1_scale: assert property (
    @(posedge clk) disable iff (!rst_b)
    pattern_scale_en[1] && light_zone == 3'h1 |->
    pattern_scale_num[1] == {1'b0, zone_scaler_mid_reg[3:0]} + 5'h01)
    else $error("zone 1 scale wrong");
  a_scaler_low: assert property (
    @(posedge clk) disable iff (!rst_b)
    zone_scaler_low_reg[7:4] == 4'h0)
    else $error("zone 0 upper bits set");
  a_boost_fields: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_to(`ADDR_BOOST_PROTECT_FREQ_POLARITY) |=> overvoltage_threshold ==
    $past(reg_wdata[2:1]) && boost_freq_1mhz == $past(reg_wdata[0]))
    else $error("boost fields wrong");
  a_boost_unused: assert property (
    @(posedge clk) disable iff (!rst_b)
    boost_reg[7:4] == 4'h0)
    else $error("unused boost bits set");
  a_hiz_code: assert property (
    @(posedge clk) disable iff (!rst_b)
    sense_input_hiz == (light_sense_gain_resistor == 7'h00))
    else $error("high impedance decode wrong");
  a_resistor_unused: assert property (
    @(posedge clk) disable iff (!rst_b)
    resistor_reg[7] == 1'b0)
    else $error("unused resistor bit set");
  a_current_step: assert property (
    @(posedge clk) disable iff (!rst_b)
    light_sense_gain_resistor == 7'h7F |-> sense_full_scale_ua == 14'h4F6)
    else $error("full scale current wrong");
  a_avg_period: assert property (
    @(posedge clk) disable iff (!rst_b)
    light_config_reg[5:3] == 3'h0 |-> avg_period_cycles == 32'h001B5800)
    else $error("averaging base wrong");
  a_fast_start: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_to(`ADDR_LIGHT_SENSE_CONFIG) |=> fast_startup_en == !$past(reg_wdata[2]))
    else $error("fast startup sense wrong");
  a_input_mode: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_to(`ADDR_LIGHT_SENSE_CONFIG) |=> sense_input_pwm == $past(reg_wdata[1])
    && ambient_light_sensing_en == $past(reg_wdata[0]))
    else $error("input mode wrong");
  a_cfg_unused: assert property (
    @(posedge clk) disable iff (!rst_b)
    light_config_reg[7:6] == 2'h0)
    else $error("unused config bits set");
  a_scale_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    !pattern_scale_en[1] |-> pattern_scale_num[1] == 5'h10)
    else $error("unscaled pattern not full scale");
  a_pwm_polarity: assert property (
    @(posedge clk) disable iff (!rst_b)
    $stable(pwm_level_reg) && !boost_reg[3] |-> pwm_active == pwm_level_reg)
    else $error("pwm polarity wrong");
  a_pwm_filter: assert property (
    @(posedge clk) disable iff (!rst_b)
    pwm_sync_reg[1] == pwm_sync_reg[2] |=>
    pwm_level_reg == $past(pwm_sync_reg[2]))
    else $error("pwm filter level wrong");

endmodule
`default_nettype wire

/* tb_lighting_bank_als_config_regs.sv */
// Self-checking bench for the lighting configuration register group.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/10ps
`default_nettype none
`include "light_cfg_defs.svh"
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
  end \
end

module tb_lighting_bank_als_config_regs;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lv_bank_ctrl;
  logic reg_wr, reg_hit, pwm_pin, bst_freq, pwm_active, hiz;
  logic [3:0] lv_sel, pat_en, scl_en, ignore;
  logic [2:0] light_zone;
  logic [5:0] bank_en;
  logic [4:0] num [4];
  logic [1:0] ovt;
  logic [6:0] gain;
  logic [13:0] fs_ua;
  logic [31:0] avg;
  logic fast_en, in_pwm, sense_en;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [7:0] ADR [8] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B,
    8'h2C, 8'h30, 8'h31};
  localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h20};
  localparam logic [7:0] MSK [8] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'h0F, 8'h7F, 8'h3F};
  localparam logic [4:0] ZEXP [8] = '{5'h08, 5'h01, 5'h0A, 5'h06, 5'h10,
    5'h10, 5'h10, 5'h10};
  localparam logic [7:0] RES [4] = '{8'h01, 8'h7F, 8'h40, 8'h00};
  localparam logic [31:0] BASE = 32'(`AVG_BASE_CYCLES);

  always #5 clk = ~clk;

  light_cfg_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

  lighting_bank_als_config_regs uut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .lv_bank_ctrl(lv_bank_ctrl),
    .lv_bank_pattern_sel(lv_sel), .light_zone(light_zone),
    .pwm_pin(pwm_pin), .bank_en(bank_en), .pattern_en(pat_en),
    .pattern_scale_en(scl_en), .mapper_target_ignore(ignore),
    .pattern_scale_num(num), .overvoltage_threshold(ovt),
    .boost_freq_1mhz(bst_freq), .pwm_active(pwm_active),
    .light_sense_gain_resistor(gain), .sense_input_hiz(hiz),
    .sense_full_scale_ua(fs_ua), .avg_period_cycles(avg),
    .fast_startup_en(fast_en), .sense_input_pwm(in_pwm),
    .ambient_light_sensing_en(sense_en));

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic check_reset();
    logic [7:0] d;
    logic h;
    for (int i = 0; i < 8; i++) begin
      host.read_reg(ADR[i], d, h);
      `CHK({h, d}, {1'b1, RST[i]})
    end
    `CHK(bank_en, 6'h00)
    `CHK({scl_en, pat_en}, 8'h00)
    `CHK({num[0], num[3]}, 10'h210)
    `CHK(hiz, 1'b1)
    `CHK(avg, BASE << 4)
    `CHK({fast_en, in_pwm, sense_en}, 3'h4)
    `CHK({ovt, bst_freq}, 3'h0)
  endtask

  // All-ones writes expose unused bits; unmapped places stay silent
  task automatic check_masks();
    logic [7:0] d;
    logic h;
    for (int i = 0; i < 8; i++) begin
      host.write_reg(ADR[i], 8'hFF);
      host.read_reg(ADR[i], d, h);
      `CHK(d, MSK[i])
    end
    `CHK({scl_en, pat_en}, 8'hFF)
    `CHK(avg, BASE << 7)
    host.write_reg(8'h2D, 8'hA5);
    host.read_reg(8'h2C, d, h);
    `CHK(d, 8'h0F)
    host.read_reg(8'h2D, d, h);
    `CHK({h, d}, 9'h000)
    host.write_reg(8'h27, 8'h21);
    `CHK(bank_en, 6'h21)
  endtask

  task automatic check_scaler();
    host.write_reg(8'h29, 8'hF5);
    host.write_reg(8'h2A, 8'h90);
    host.write_reg(8'h2B, 8'h07);
    host.write_reg(8'h28, 8'h26);
    `CHK({scl_en, pat_en}, 8'h52)
    for (int z = 0; z < 8; z++) begin
      @(negedge clk);
      light_zone = 3'(z);
      #1;
      `CHK(num[0], ZEXP[z])
      `CHK({num[1], num[2], num[3]}, {5'h10, ZEXP[z], 5'h10})
    end
  endtask

  task automatic wait_pwm(input logic e);
    int k;
    k = 0;
    while (pwm_active !== e && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK(pwm_active, e)
    if (k == 20) print_verdict();
  endtask

  task automatic check_boost();
    for (int t = 0; t < 4; t++) begin
      host.write_reg(8'h2C, 8'(t << 1) | 8'(t & 1));
      `CHK({ovt, bst_freq}, {2'(t), 1'(t & 1)})
    end
    @(negedge clk);
    pwm_pin = 1'b1;
    host.write_reg(8'h2C, 8'h00);
    wait_pwm(1'b1);
    host.write_reg(8'h2C, 8'h08);
    wait_pwm(1'b0);
    pwm_pin = 1'b0;
    wait_pwm(1'b1);
  endtask

  task automatic check_sense();
    for (int i = 0; i < 4; i++) begin
      host.write_reg(8'h30, RES[i]);
      `CHK({gain, fs_ua}, {RES[i][6:0], 14'(RES[i] * 10)})
      `CHK(hiz, RES[i] == 8'h00)
    end
    for (int c = 0; c < 8; c++) begin
      host.write_reg(8'h31, 8'(c << 3) | 8'(c));
      `CHK(avg, BASE << c)
      `CHK({fast_en, in_pwm, sense_en}, 3'(c) ^ 3'h4)
    end
  endtask

  task automatic check_mapper();
    for (int c = 0; c < 4; c++) begin
      @(negedge clk);
      lv_bank_ctrl = {4{2'(c)}};
      lv_sel = 4'hA;
      #1;
      `CHK(ignore, (c >= 2) ? 4'hA : 4'h0)
    end
    @(negedge clk);
    lv_bank_ctrl = 8'hE4;
    lv_sel = 4'hF;
    #1;
    `CHK(ignore, 4'hC)
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    lv_bank_ctrl = 8'h00;
    lv_sel = 4'h0;
    light_zone = 3'h0;
    pwm_pin = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    check_reset();
    check_masks();
    check_scaler();
    check_boost();
    check_sense();
    check_mapper();
    // Mid-run reset must restore every default at once, then release
    @(negedge clk);
    rst_b = 1'b0;
    light_zone = 3'h0;
    check_reset();
    @(negedge clk);
    rst_b = 1'b1;
    check_reset();
    host.write_reg(8'h27, 8'h3F);
    `CHK(bank_en, 6'h3F)
    print_verdict();
  end
endmodule
`default_nettype wire
